// ### dual_pio_port_decode.sv
// two dual-port parallel chips mapped into external data memory
// Operation
// - first chip answers at high bytes 80h to 83h, low byte ignored
// - second chip answers at high bytes a0h to a3h, low byte ignored
// - data write changes only bits set as outputs
// - data read gives latch for outputs, pin level for inputs
// - writing ffh to control arms mode; next control byte is direction mask
// - mask bit zero makes output, one makes input
// - direction holds until a new control sequence for that port
// - chip selected only while io request select is low
// - fetch cycle indicator held inactive high
// - a8 high selects control, a9 high selects port b
`timescale 1ns/1ps
module dual_pio_port_decode
#(
  parameter int unsigned WIDTH = 8
)
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [15:0]           addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_n_i,
  input  wire logic                  rd_n_i,
  input  wire logic                  io_request_select_n_i,
  output logic      [7:0]            rdata_o,
  output logic                       rdata_oe_o,
  output logic                       fetch_cycle_indicator_o,
  input  wire logic [4*WIDTH-1:0]    pin_i,
  output logic      [4*WIDTH-1:0]    pin_o,
  output logic      [4*WIDTH-1:0]    pin_oe_o
);
  typedef enum logic [1:0] {
    MODE_DATA = 2'b01,
    MODE_MASK = 2'b10
  } ctrl_state_t;

  port_sel_if sel ();
  ctrl_state_t      state      [pio_decode_pkg::PORTS];
  ctrl_state_t      next_state [pio_decode_pkg::PORTS];
  logic [WIDTH-1:0] latch      [pio_decode_pkg::PORTS];
  logic [WIDTH-1:0] next_latch [pio_decode_pkg::PORTS];
  logic [WIDTH-1:0] dir        [pio_decode_pkg::PORTS];
  logic [WIDTH-1:0] next_dir   [pio_decode_pkg::PORTS];
  logic [7:0]       next_rdata;
  logic             wr_edge;
  logic             wr_n_q;
  logic             next_wr_n;
  logic             next_oe;

  pio_addr_decode u_decode
  (
    .addr_i                (addr_i),
    .io_request_select_n_i (io_request_select_n_i),
    .sel                   (sel)
  );

  // write acts once on the falling edge of write strobe
  assign wr_edge = wr_n_q & ~wr_n_i & sel.hit;
  // no fetch cycles ever signalled
  assign fetch_cycle_indicator_o = 1'b1;

  genvar g;
  generate
    for (g = 0; g < pio_decode_pkg::PORTS; g++)
    begin : g_port
      logic sel_me;
      assign sel_me = wr_edge && (sel.port_idx == 2'(g));
      // per port control sequence, latch and direction
      always_comb
      begin
        next_state[g] = state[g];
        next_latch[g] = latch[g];
        next_dir[g]   = dir[g];
        if (sel_me && !sel.is_ctrl)
        begin
          next_latch[g] = (latch[g] & dir[g]) | (wdata_i & ~dir[g]);
        end
        else if (sel_me && sel.is_ctrl)
        begin
          case (state[g])
            MODE_DATA:
            begin
              if (wdata_i == pio_decode_pkg::MODE_CMD)
                next_state[g] = MODE_MASK;
            end
            MODE_MASK:
            begin
              next_dir[g]   = wdata_i;
              next_state[g] = MODE_DATA;
            end
            default:
            begin
              next_state[g] = MODE_DATA;
            end
          endcase
        end
      end
      // register the port state
      always_ff @(posedge clk_i)
      begin
        if (!reset_n_i)
        begin
          state[g] <= MODE_DATA;
          latch[g] <= pio_decode_pkg::LATCH_RESET;
          dir[g]   <= pio_decode_pkg::DIR_RESET;
        end
        else
        begin
          state[g] <= next_state[g];
          latch[g] <= next_latch[g];
          dir[g]   <= next_dir[g];
        end
      end
      // zero in mask drives the pin
      assign pin_o[g*WIDTH +: WIDTH]    = latch[g];
      assign pin_oe_o[g*WIDTH +: WIDTH] = ~dir[g];
    end
  endgenerate

  // read mux: latch for outputs, pins for inputs
  always_comb
  begin
    next_rdata = 8'h00;
    next_oe    = 1'b0;
    next_wr_n  = wr_n_i; // strobe history for edge detect
    if (sel.hit && !rd_n_i && !sel.is_ctrl)
    begin
      next_oe    = 1'b1;
      next_rdata = (latch[sel.port_idx] & ~dir[sel.port_idx])
                 | (pin_i[sel.port_idx*WIDTH +: WIDTH] & dir[sel.port_idx]);
    end
  end
  // register read data and strobe history
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o    <= 8'h00;
      rdata_oe_o <= 1'b0;
      wr_n_q     <= 1'b1;
    end
    else
    begin
      rdata_o    <= next_rdata;
      rdata_oe_o <= next_oe;
      wr_n_q     <= next_wr_n;
    end
  end

  // checks on the port data path
  out_only_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    1'b1 |=> ((latch[0] ^ $past(latch[0])) & $past(dir[0])) == 8'h00)
    else $error("input bit latch changed");
  out_take_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (g_port[3].sel_me && !sel.is_ctrl)
      |=> (pin_o[31:24] & ~$past(dir[3])) == ($past(wdata_i) & ~$past(dir[3])))
    else $error("output bit not written");
  read_mix_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sel.hit && !rd_n_i && !sel.is_ctrl && sel.port_idx == 2'd0) |=>
      rdata_o == (($past(latch[0]) & ~$past(dir[0])) | ($past(pin_i[7:0]) & $past(dir[0]))))
    else $error("read data mix wrong");
  read_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_n_i |=> !rdata_oe_o && rdata_o == 8'h00)
    else $error("read data outside a read");
  // checks on the control sequence
  arm_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (g_port[0].sel_me && sel.is_ctrl && state[0] == MODE_DATA
      && wdata_i == pio_decode_pkg::MODE_CMD) |=> state[0] == MODE_MASK)
    else $error("mode not armed");
  mask_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (g_port[0].sel_me && sel.is_ctrl && state[0] == MODE_MASK) |=> dir[0] == $past(wdata_i))
    else $error("mask not taken");
  oe_dir_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (g_port[3].sel_me && sel.is_ctrl && state[3] == MODE_MASK)
      |=> pin_oe_o[31:24] == ~$past(wdata_i))
    else $error("enable not from mask");
  dir_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state[1] == MODE_DATA) |=> $stable(dir[1]))
    else $error("direction changed outside sequence");
  dir_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (g_port[0].sel_me && sel.is_ctrl && state[0] == MODE_DATA) |=> $stable(dir[0]))
    else $error("direction changed by arming byte");
  // checks on the decode and the fixed pins
  sel_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    io_request_select_n_i |=> !rdata_oe_o)
    else $error("read without select");
  wr_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    io_request_select_n_i |=> $stable(latch[2]) && $stable(dir[2]) && $stable(state[2]))
    else $error("write without select");
  fetch_high_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    fetch_cycle_indicator_o)
    else $error("fetch indicator low");
  first_hit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!io_request_select_n_i && addr_i[15:10] == pio_decode_pkg::FIRST_A_DATA[15:10])
      |-> sel.hit && !sel.port_idx[1])
    else $error("first chip not selected");
  second_hit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!io_request_select_n_i && addr_i[15:10] == pio_decode_pkg::SECOND_A_DATA[15:10])
      |-> sel.hit && sel.port_idx[1])
    else $error("second chip not selected");
  no_hit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sel.hit |-> (addr_i[15:10] == pio_decode_pkg::FIRST_A_DATA[15:10]
      || addr_i[15:10] == pio_decode_pkg::SECOND_A_DATA[15:10]))
    else $error("select outside both groups");
  ctrl_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sel.hit && !rd_n_i && addr_i[pio_decode_pkg::CD_BIT]) |=> !rdata_oe_o)
    else $error("control location read back");
  port_b_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_edge && addr_i[pio_decode_pkg::BA_BIT]) |=> $stable(latch[0]) && $stable(dir[0]))
    else $error("port b write reached port a");
  chip_sel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sel.hit && addr_i[15:8] == pio_decode_pkg::SECOND_B_DATA[15:8]) |-> sel.port_idx == 2'd3)
    else $error("chip or port select wrong");
  // main scenarios
  cv_arm: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    state[2] == MODE_MASK ##[1:20] state[2] == MODE_DATA);
  cv_read: cover property (@(posedge clk_i) disable iff (!reset_n_i) rdata_oe_o);
  cv_mixed: cover property (@(posedge clk_i) disable iff (!reset_n_i) dir[3] == 8'haa);
  cv_reject: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    io_request_select_n_i && !wr_n_i);
  cv_pin_read: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    sel.hit && !rd_n_i && sel.port_idx == 2'd0 && dir[0] == 8'hf0);
endmodule : dual_pio_port_decode

// ### pin_far_model.sv
// far side of the port pins: pull-ups plus an optional external driver
`timescale 1ns/1ps
module pin_far_model
(
  input  wire logic [31:0] pin_o_i,
  input  wire logic [31:0] pin_oe_i,
  input  wire logic        ext_en_i,
  input  wire logic [31:0] ext_val_i,
  output logic      [31:0] level_o
);
  // driven bits follow the latch, released bits the driver or the pull-up
  assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & (ext_en_i ? ext_val_i : 32'hffffffff));
endmodule : pin_far_model

// ### pio_addr_decode.sv
// address decode for both parallel chips
`timescale 1ns/1ps
module pio_addr_decode
(
  input  wire logic [15:0] addr_i,
  input  wire logic        io_request_select_n_i,
  port_sel_if.decoder      sel
);
  logic [7:0] high_byte;

  // high byte only, low byte ignored
  assign high_byte = addr_i[15:8];
  always_comb
  begin
    sel.hit = 1'b0;
    if (io_request_select_n_i)
    begin
      sel.hit = 1'b0;
    end
    else if ((high_byte & pio_decode_pkg::GROUP_MASK) == pio_decode_pkg::FIRST_GROUP)
    begin
      sel.hit = 1'b1;
    end
    else if ((high_byte & pio_decode_pkg::GROUP_MASK) == pio_decode_pkg::SECOND_GROUP)
    begin
      sel.hit = 1'b1;
    end
  end
  // chip by A13, port by A9, control by A8
  assign sel.port_idx = {addr_i[pio_decode_pkg::CHIP_BIT], addr_i[pio_decode_pkg::BA_BIT]};
  assign sel.is_ctrl  = addr_i[pio_decode_pkg::CD_BIT];
endmodule : pio_addr_decode

// ### pio_decode_pkg.sv
// constants for the dual parallel port decode block
package pio_decode_pkg;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PORTS         = 4;
  localparam logic [7:0]  FIRST_GROUP   = 8'h80;
  localparam logic [7:0]  SECOND_GROUP  = 8'ha0;
  localparam logic [7:0]  GROUP_MASK    = 8'hfc;
  localparam int unsigned CD_BIT        = 8;
  localparam int unsigned BA_BIT        = 9;
  localparam int unsigned CHIP_BIT      = 13;
  localparam logic [7:0]  MODE_CMD      = 8'hff;
  localparam logic [7:0]  DIR_RESET     = 8'hff;
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  localparam logic [15:0] FIRST_A_DATA  = 16'h8000;
  localparam logic [15:0] FIRST_A_CTRL  = 16'h8100;
  localparam logic [15:0] FIRST_B_DATA  = 16'h8200;
  localparam logic [15:0] FIRST_B_CTRL  = 16'h8300;
  localparam logic [15:0] SECOND_A_DATA = 16'ha000;
  localparam logic [15:0] SECOND_A_CTRL = 16'ha100;
  localparam logic [15:0] SECOND_B_DATA = 16'ha200;
  localparam logic [15:0] SECOND_B_CTRL = 16'ha300;
endpackage : pio_decode_pkg

// ### port_sel_if.sv
// select signals from decode to the port bank
`timescale 1ns/1ps
interface port_sel_if;
  logic       hit;
  logic [1:0] port_idx;
  logic       is_ctrl;
  modport decoder (output hit, output port_idx, output is_ctrl);
  modport bank    (input hit, input port_idx, input is_ctrl);
endinterface : port_sel_if

// ### tb_dual_pio_port_decode.sv
// self-checking bench for the dual parallel port decode block
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_dual_pio_port_decode;
  logic        clk_i     = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [15:0] addr_i    = 16'h0000;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_n_i    = 1'b1;
  logic        rd_n_i    = 1'b1;
  logic        sel_n     = 1'b1;
  logic        ext_en    = 1'b0;
  logic [7:0]  rdata_o;
  logic        rdata_oe_o;
  logic        fetch_o;
  logic [31:0] pin_i;
  logic [31:0] pin_o;
  logic [31:0] pin_oe_o;
  int          fails     = 0;
  int          cmp_count = 0;
  logic [7:0]  mask [4]  = '{8'hf0, 8'h00, 8'h00, 8'haa};
  logic [15:0] base [4]  = '{16'h8000, 16'h8200, 16'ha000, 16'ha200};

  dual_pio_port_decode dual_pio_port_decode_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
    .io_request_select_n_i(sel_n), .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o),
    .fetch_cycle_indicator_o(fetch_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  pin_far_model pin_far_model_i (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .ext_en_i(ext_en),
    .ext_val_i(32'h3c3c3c3c), .level_o(pin_i));

  // clock at 25 MHz
  initial forever #20 clk_i = ~clk_i;

  // one host access, select driven from sel around it; returns {oe, data}
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic wr,
                     input logic sel, output logic [8:0] r);
    @(negedge clk_i);
    addr_i  = a;
    wdata_i = d;
    sel_n   = sel;
    wr_n_i  = ~wr;
    rd_n_i  = wr;
    repeat (2) @(negedge clk_i);
    r      = {rdata_oe_o, rdata_o};
    wr_n_i = 1'b1;
    rd_n_i = 1'b1;
    sel_n  = 1'b1;
    @(negedge clk_i);
  endtask : bus

  // counts and verdict
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // hang guard
  initial
  begin
    #2000000;
    fails++;
    results();
  end

  // main sequence
  initial
  begin : main
    logic [8:0] r;
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    `CHK(pin_oe_o, 32'h00000000)
    `CHK(fetch_o, 1'b1)
    $display("test reset done");
    for (int p = 0; p < 4; p++)
    begin
      bus(base[p] + 16'h0155, pio_decode_pkg::MODE_CMD, 1'b1, 1'b0, r);
      bus(base[p] + 16'h01aa, mask[p], 1'b1, 1'b0, r);
      `CHK(pin_oe_o[p*8 +: 8], ~mask[p])
      bus(base[p] + 16'h0033, 8'h55, 1'b1, 1'b0, r);
      `CHK(pin_o[p*8 +: 8], 8'h55 & ~mask[p])
    end
    $display("test direction and write done");
    for (int k = 0; k < 2; k++)
    begin
      ext_en = k[0];
      for (int p = 0; p < 4; p++)
      begin
        bus(base[p] + 16'h00c3, 8'h00, 1'b0, 1'b0, r);
        `CHK(r, {1'b1, (8'h55 & ~mask[p]) | ((k[0] ? 8'h3c : 8'hff) & mask[p])})
      end
    end
    $display("test read done");
    bus(16'h8000, 8'hff, 1'b1, 1'b1, r);
    bus(16'h9000, 8'hff, 1'b1, 1'b0, r);
    bus(16'h8100, 8'h0f, 1'b1, 1'b0, r);
    `CHK(pin_o[7:0], 8'h05)
    `CHK(pin_oe_o[7:0], 8'h0f)
    bus(16'h8000, 8'h00, 1'b0, 1'b1, r);
    `CHK(r[8], 1'b0)
    bus(16'h8100, 8'h00, 1'b0, 1'b0, r);
    `CHK(r[8], 1'b0)
    bus(16'h8100, pio_decode_pkg::MODE_CMD, 1'b1, 1'b0, r);
    bus(16'h8100, 8'h0f, 1'b1, 1'b0, r);
    `CHK(pin_oe_o[15:0], 16'hfff0)
    $display("test refusal and reprogram done");
    results();
  end
endmodule : tb_dual_pio_port_decode
